// ---- spi_pkg.sv ----
// Purpose: shared constants and types for the serial port block
// Assumes: core clock of 200 MHz, eight-bit characters
// Notes: the select line is active low
package spi_pkg;
	localparam int unsigned CHAR_BITS     = 8;
	localparam logic [2:0]  LAST_BIT      = 3'h7;
	localparam logic [3:0]  LAST_EDGE     = 4'hF;
	localparam logic [7:0]  DUMMY_BYTE    = 8'h00;
	localparam logic [7:0]  RX_BUF_RESET  = 8'h00;
	localparam logic        TX_FLAG_RESET = 1'b1;
	localparam logic        SELECT_ACTIVE = 1'b0;
	localparam logic        STEM_CONFLICT = 1'b0;
	localparam logic        STEM_ENABLE   = 1'b1;
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned HALF_SCLK_NS  = 20;
	localparam int unsigned HALF_SCLK_CYC = (HALF_SCLK_NS * 1000) / CLK_PERIOD_PS;
	localparam int unsigned DIV_W         = 8;
	localparam int unsigned SYNC_W        = 4;

	typedef enum logic [1:0] {
		M_IDLE  = 2'b00,
		M_SHIFT = 2'b01
	} master_state_t;
endpackage

// ---- spi_link_if.sv ----
// Purpose: carrier between the core and the link-clock shifter
// Assumes: tx_word, cpol and cpha are held stable around link edges
// Notes: rx_word is valid whenever done_tgl has changed
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
	logic [7:0] tx_word;
	logic       cpol;
	logic       cpha;
	logic [7:0] rx_word;
	logic       done_tgl;
	logic       mid_byte;

	modport core  (output tx_word, output cpol, output cpha,
		input rx_word, input done_tgl, input mid_byte);
	modport shift (input tx_word, input cpol, input cpha,
		output rx_word, output done_tgl, output mid_byte);
endinterface
`default_nettype wire

// ---- spi_sync.sv ----
// Purpose: two-flop synchroniser for levels and toggles
// Assumes: each bit is an independent level
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
`default_nettype none
module spi_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_t;

	sync_state_t q;
	sync_state_t d;

	always_comb begin
		d        = q;
		d.meta   = async_i;
		d.stable = q.meta;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sync_o = q.stable;
endmodule
`default_nettype wire

// ---- spi_slave_shift.sv ----
// Purpose: slave shifter clocked by the remote master's serial clock
// Assumes: cpol and cpha change only while held in reset
// Notes: samples on the rising edge of a phase-corrected clock
`timescale 1ns/1ps
`default_nettype none
module spi_slave_shift
	import spi_pkg::*;
(
	input  wire logic sclk_link_i,
	input  wire logic rst_link_i,
	input  wire logic mosi_i,
	output logic      miso_o,
	spi_link_if.shift lnk
);
	typedef struct packed {
		logic [2:0] cnt;
		logic [7:0] rx_sh;
		logic [7:0] tx_sh;
		logic [7:0] rx_word;
		logic       done_tgl;
		logic       mid;
	} slave_state_t;

	slave_state_t q;
	slave_state_t d;
	logic         out_q;
	logic         edge_clk;

	// one sample edge for all four clock settings
	assign edge_clk = sclk_link_i ^ lnk.cpol ^ lnk.cpha;

	always_comb begin
		d       = q;
		d.cnt   = q.cnt + 3'h1;
		d.mid   = (q.cnt != LAST_BIT);
		d.rx_sh = {q.rx_sh[6:0], mosi_i};
		d.tx_sh = (q.cnt == 3'h0) ? {lnk.tx_word[6:0], 1'b0} : {q.tx_sh[6:0], 1'b0};
		if (q.cnt == LAST_BIT) begin
			d.rx_word  = {q.rx_sh[6:0], mosi_i};
			d.done_tgl = ~q.done_tgl;
		end
	end

	always_ff @(posedge edge_clk or posedge rst_link_i) begin
		if (rst_link_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// launch on the edge opposite the sample; a clock that is not idle at release
	// loses this first launch in phase 1
	always_ff @(negedge edge_clk or posedge rst_link_i) begin
		if (rst_link_i) begin
			out_q <= 1'b0;
		end else begin
			out_q <= (q.cnt == 3'h0) ? lnk.tx_word[7] : q.tx_sh[7];
		end
	end

	// phase 0 must show the first bit before any edge
	assign miso_o       = (!lnk.cpha && q.cnt == 3'h0) ? lnk.tx_word[7] : out_q;
	assign lnk.rx_word  = q.rx_word;
	assign lnk.done_tgl = q.done_tgl;
	assign lnk.mid_byte = q.mid;
endmodule
`default_nettype wire

// ---- spi_serial_port_block.sv ----
// Purpose: serial peripheral port, master and slave, four clock modes
// Assumes: control inputs come from logic on clk_i; config changes under soft reset
// Notes: slave logic runs on sclk_link_i; master logic on clk_i
`timescale 1ns/1ps
`default_nettype none
module spi_serial_port_block
	import spi_pkg::*;
#(
	parameter int unsigned HALF_SCLK = HALF_SCLK_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       sclk_link_i,
	input  wire logic       software_reset_bit_i,
	input  wire logic       master_mode_i,
	input  wire logic       four_wire_i,
	input  wire logic       select_pin_mode_i,
	input  wire logic       clock_phase_select_i,
	input  wire logic       clock_polarity_select_i,
	input  wire logic [7:0] transmit_buffer_i,
	input  wire logic       tx_write_i,
	input  wire logic       rx_read_i,
	output logic      [7:0] receive_buffer_o,
	output logic            tx_buffer_empty_flag_o,
	output logic            rx_char_ready_flag_o,
	output logic            busy_flag_o,
	output logic            clock_request_o,
	output logic            sclk_o,
	output logic            sclk_oe_n_o,
	input  wire logic       mosi_i,
	output logic            mosi_o,
	output logic            mosi_oe_n_o,
	input  wire logic       miso_i,
	output logic            miso_o,
	output logic            miso_oe_n_o,
	input  wire logic       select_pin_i,
	output logic            select_pin_o,
	output logic            select_pin_oe_n_o
);
	typedef struct packed {
		master_state_t    st;
		logic             swrst;
		logic             link_rst;
		logic             cpol;
		logic             cpha;
		logic [7:0]       tx_hold;
		logic             armed;
		logic             tx_flag;
		logic             rx_flag;
		logic [7:0]       rx_buf;
		logic [7:0]       sh;
		logic [7:0]       rx_sh;
		logic             mosi;
		logic             sclk;
		logic [3:0]       edge_cnt;
		logic [DIV_W-1:0] div_cnt;
		logic             done_seen;
		logic             mid_seen;
		logic [7:0]       tx_word;
	} core_state_t;

	localparam core_state_t CORE_RST = '{
		st: M_IDLE, swrst: 1'b1, link_rst: 1'b1, cpol: 1'b0, cpha: 1'b0,
		tx_hold: DUMMY_BYTE, armed: 1'b0, tx_flag: TX_FLAG_RESET, rx_flag: 1'b0,
		rx_buf: RX_BUF_RESET, sh: DUMMY_BYTE, rx_sh: DUMMY_BYTE, mosi: 1'b0,
		sclk: 1'b0, edge_cnt: 4'h0, div_cnt: '0, done_seen: 1'b0, mid_seen: 1'b0,
		tx_word: DUMMY_BYTE};

	core_state_t       q;
	core_state_t       d;
	logic [SYNC_W-1:0] sync_in;
	logic [SYNC_W-1:0] sync_out;
	logic              miso_s;
	logic              sel_s;
	logic              done_s;
	logic              mid_s;
	logic              conflict;
	logic              sel_ok;
	logic              tick;
	logic              leading;
	logic              sample_now;
	logic              set_tx;
	logic              set_rx;
	logic [7:0]        rx_next;
	logic              link_rst;
	logic              slave_miso;
	logic              drive_m;

	spi_link_if lnk ();

	assign sync_in = {miso_i, select_pin_i, lnk.done_tgl, lnk.mid_byte};

	spi_sync #(
		.WIDTH (SYNC_W)
	) u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i (sync_in),
		.sync_o  (sync_out)
	);

	assign {miso_s, sel_s, done_s, mid_s} = sync_out;

	always_comb begin
		d          = q;
		set_tx     = 1'b0;
		set_rx     = 1'b0;
		conflict   = master_mode_i & four_wire_i & (select_pin_mode_i == STEM_CONFLICT);
		sel_ok     = ~conflict | (sel_s == SELECT_ACTIVE);
		tick       = (q.div_cnt == DIV_W'(HALF_SCLK - 1));
		leading    = ~q.edge_cnt[0];
		sample_now = leading ^ q.cpha;
		rx_next    = {q.rx_sh[6:0], miso_s};
		d.swrst     = software_reset_bit_i;
		d.link_rst  = software_reset_bit_i | master_mode_i;
		d.cpol      = clock_polarity_select_i;
		d.cpha      = clock_phase_select_i;
		d.done_seen = done_s;
		d.mid_seen  = mid_s;
		d.tx_word   = q.armed ? q.tx_hold : DUMMY_BYTE;
		case (q.st)
			M_IDLE: begin
				d.sclk     = q.cpol;
				d.div_cnt  = '0;
				d.edge_cnt = 4'h0;
				// a blocked start waits; the data stays armed
				if (master_mode_i && q.armed && sel_ok) begin
					d.st    = M_SHIFT;
					d.sh    = q.tx_hold;
					d.mosi  = q.tx_hold[7];
					d.armed = 1'b0;
					set_tx  = 1'b1;
				end
			end
			M_SHIFT: begin
				d.div_cnt = q.div_cnt + DIV_W'(1);
				if (!sel_ok || !master_mode_i) begin
					// the aborted character is lost, software must write it again
					d.st   = M_IDLE;
					d.sclk = q.cpol;
				end else if (tick) begin
					d.div_cnt  = '0;
					d.sclk     = ~q.sclk;
					d.edge_cnt = q.edge_cnt + 4'h1;
					if (sample_now) begin
						d.rx_sh = rx_next;
					end else if (q.cpha) begin
						d.mosi = q.sh[7];
						d.sh   = {q.sh[6:0], 1'b0};
					end else begin
						d.mosi = q.sh[6];
						d.sh   = {q.sh[6:0], 1'b0};
					end
					if (q.edge_cnt == LAST_EDGE) begin
						d.st     = M_IDLE;
						d.rx_buf = sample_now ? rx_next : q.rx_sh;
						set_rx   = 1'b1;
					end
				end
			end
			default: begin
				d.st = M_IDLE;
			end
		endcase
		if (!master_mode_i) begin
			// a slave consumes the armed byte once its first bit is sampled
			if (mid_s && !q.mid_seen && q.armed) begin
				d.armed = 1'b0;
				set_tx  = 1'b1;
			end
			if (done_s != q.done_seen) begin
				d.rx_buf = lnk.rx_word;
				set_rx   = 1'b1;
			end
		end
		if (tx_write_i) begin
			d.tx_hold = transmit_buffer_i;
			d.armed   = 1'b1;
		end
		// set wins over clear
		d.tx_flag = set_tx | (q.tx_flag & ~tx_write_i);
		d.rx_flag = set_rx | (q.rx_flag & ~rx_read_i);
		if (q.swrst) begin
			d           = CORE_RST;
			d.swrst     = software_reset_bit_i;
			d.cpol      = clock_polarity_select_i;
			d.cpha      = clock_phase_select_i;
			d.sclk      = clock_polarity_select_i;
			d.done_seen = done_s;
			d.mid_seen  = mid_s;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= CORE_RST;
		end else begin
			q <= d;
		end
	end

	assign lnk.tx_word = q.tx_word;
	assign lnk.cpol    = q.cpol;
	assign lnk.cpha    = q.cpha;
	// the shifter is held whenever the core is master or in soft reset
	assign link_rst    = rst_i | q.link_rst;

	spi_slave_shift u_slave (
		.sclk_link_i (sclk_link_i),
		.rst_link_i  (link_rst),
		.mosi_i      (mosi_i),
		.miso_o      (slave_miso),
		.lnk         (lnk)
	);

	// a stuck busy would keep the clock requested; busy is only true state here
	assign busy_flag_o     = (q.st == M_SHIFT) | q.armed | (~master_mode_i & mid_s);
	assign clock_request_o = busy_flag_o;

	assign receive_buffer_o       = q.rx_buf;
	assign tx_buffer_empty_flag_o = q.tx_flag;
	assign rx_char_ready_flag_o   = q.rx_flag;

	assign drive_m     = master_mode_i & ~q.swrst & sel_ok;
	assign sclk_o      = q.sclk;
	assign sclk_oe_n_o = ~drive_m;
	assign mosi_o      = q.mosi;
	assign mosi_oe_n_o = ~drive_m;
	assign miso_o      = slave_miso;
	assign miso_oe_n_o = ~(~master_mode_i & ~q.swrst & (~four_wire_i | (sel_s == SELECT_ACTIVE)));
	assign select_pin_o      = (q.st == M_SHIFT) ? SELECT_ACTIVE : ~SELECT_ACTIVE;
	assign select_pin_oe_n_o = ~(master_mode_i & four_wire_i & ~q.swrst
		& (select_pin_mode_i == STEM_ENABLE));

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_launch;
		q.st == M_IDLE ##1 q.st == M_SHIFT;
	endsequence

	sequence s_lose_select;
		!q.swrst && q.st == M_SHIFT && conflict && sel_s != SELECT_ACTIVE;
	endsequence

	a_char_length: assert property (s_launch |-> (q.st == M_SHIFT)[*8])
		else $error("master character ended too early");

	a_clock_request: assert property (busy_flag_o |-> clock_request_o)
		else $error("clock request dropped while busy");

	a_slave_rx_store: assert property (!q.swrst && !master_mode_i && done_s != q.done_seen
		|=> rx_char_ready_flag_o && receive_buffer_o == $past(lnk.rx_word))
		else $error("slave byte not stored");

	a_idle_level: assert property (q.st == M_IDLE && !$past(q.swrst) && $stable(q.cpol)
		|-> sclk_o == q.cpol)
		else $error("serial clock not at idle level");

	a_soft_reset_hold: assert property (q.swrst |=> q.st == M_IDLE && !q.armed
		&& !rx_char_ready_flag_o && tx_buffer_empty_flag_o)
		else $error("soft reset did not hold the port");

	a_select_blocks: assert property (!q.swrst && q.st == M_IDLE && conflict
		&& sel_s != SELECT_ACTIVE |=> q.st == M_IDLE)
		else $error("transfer started with select inactive");

	a_enable_drive: assert property (q.st == M_SHIFT && four_wire_i && master_mode_i
		&& select_pin_mode_i == STEM_ENABLE && !q.swrst
		|-> select_pin_o == SELECT_ACTIVE && !select_pin_oe_n_o)
		else $error("enable not driven during transfer");

	a_abort_transfer: assert property (s_lose_select
		|=> q.st == M_IDLE ##1 sclk_o == $past(q.cpol, 2))
		else $error("transfer not aborted on select loss");

	a_busy_pending: assert property ((q.armed || q.st == M_SHIFT) |-> busy_flag_o)
		else $error("busy low with character pending");

	// busy must not stick once the final bit is out and nothing waits
	a_busy_clears: assert property (master_mode_i && q.st == M_SHIFT && tick && sel_ok
		&& q.edge_cnt == LAST_EDGE && !q.armed && !tx_write_i |=> !busy_flag_o)
		else $error("busy stayed high after the last bit");
endmodule
`default_nettype wire

// ---- spi_remote_model.sv ----
// Purpose: far-side serial device, slave to a master port or master to a slave port
// Assumes: polarity and phase change only between frames
// Notes: link clock stands at its idle level outside frames
`timescale 1ns/1ps
`default_nettype none
module spi_remote_model (
	input  wire logic cpol_i,
	input  wire logic cpha_i,
	input  wire logic sclk_i,
	input  wire logic mosi_i,
	input  wire logic miso_i,
	output logic      sclk_link_o,
	output logic      mosi_o,
	output logic      miso_o
);
	logic [7:0] s_byte;
	logic [7:0] got;
	logic [4:0] cnt;
	logic [4:0] n;
	logic       frame;
	logic       lvl;
	initial begin
		s_byte = 8'h00;
		got = 8'h00;
		cnt = 5'h10;
		frame = 1'b0;
		lvl = 1'b0;
		mosi_o = 1'b1;
	end
	// parked at idle whenever no frame runs, so release of soft reset sees idle
	assign sclk_link_o = frame ? lvl : cpol_i;
	always_comb n = cnt - {4'h0, cpha_i};
	// past the byte the line shows the inverse, not a kind leftover
	always_comb miso_o = (cnt >= 5'h10) ? ~s_byte[0] : s_byte[3'h7 - n[3:1]];
	always @(sclk_i) begin
		if (cnt < 5'h10) begin
			if (cnt[0] == cpha_i) got = {got[6:0], mosi_i};
			cnt = cnt + 5'h01;
		end
	end
	task automatic arm(input logic [7:0] b);
		s_byte = b;
		cnt = 5'h00;
	endtask
	task automatic send(input logic [7:0] b, output logic [7:0] r);
		frame = 1'b1;
		lvl = cpol_i;
		for (int i = 7; i >= 0; i--) begin
			if (!cpha_i) mosi_o = b[i];
			#62.5 lvl = ~cpol_i;
			if (cpha_i) mosi_o = b[i];
			else r[i] = miso_i;
			#62.5 lvl = cpol_i;
			if (cpha_i) r[i] = miso_i;
		end
		#62.5 mosi_o = ~b[0];
		frame = 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- tb_spi_serial_port_block.sv ----
// Purpose: self-checking bench for the serial port block
// Assumes: half serial clock of 4 core cycles
// Notes: link clock comes from the remote model, 125 ns period
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; $display("ERROR at %0t got %0h exp %0h", $time, (a), (b)); end end
module tb_spi_serial_port_block;
	import spi_pkg::*;
	logic       clk_i, rst_i, swrst, master, fw, stem, cpha, cpol, wr, rd, sel_tb;
	logic [7:0] tx_data, rbuf;
	logic       txf, rxf, busy, creq, sclk, sclk_oen, mosi_w, mosi_oen;
	logic       miso_w, miso_oen, sel_o, sel_oen, sel_w, lclk, mosi_m, miso_m;
	int         error_cnt = 0;
	int         checks_done = 0;
	logic [7:0] txt [4] = '{8'hA5, 8'h00, 8'h81, 8'h5A};
	logic [7:0] rxt [4] = '{8'h3C, 8'hFF, 8'h7E, 8'hC3};
	assign sel_w = sel_oen ? sel_tb : sel_o;
	spi_serial_port_block #(.HALF_SCLK(4)) uut (.clk_i(clk_i), .rst_i(rst_i),
		.sclk_link_i(lclk), .software_reset_bit_i(swrst), .master_mode_i(master),
		.four_wire_i(fw), .select_pin_mode_i(stem), .clock_phase_select_i(cpha),
		.clock_polarity_select_i(cpol), .transmit_buffer_i(tx_data), .tx_write_i(wr),
		.rx_read_i(rd), .receive_buffer_o(rbuf), .tx_buffer_empty_flag_o(txf),
		.rx_char_ready_flag_o(rxf), .busy_flag_o(busy), .clock_request_o(creq),
		.sclk_o(sclk), .sclk_oe_n_o(sclk_oen), .mosi_i(mosi_m), .mosi_o(mosi_w),
		.mosi_oe_n_o(mosi_oen), .miso_i(miso_m), .miso_o(miso_w), .miso_oe_n_o(miso_oen),
		.select_pin_i(sel_w), .select_pin_o(sel_o), .select_pin_oe_n_o(sel_oen));
	spi_remote_model remote (.cpol_i(cpol), .cpha_i(cpha), .sclk_i(sclk), .mosi_i(mosi_w),
		.miso_i(miso_w), .sclk_link_o(lclk), .mosi_o(mosi_m), .miso_o(miso_m));
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic pulse_wr(input logic [7:0] d);
		tx_data = d;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
	endtask
	task automatic pulse_rd;
		rd = 1'b1;
		tick(1);
		rd = 1'b0;
		`CHK(rxf, 1'b0)
	endtask
	task automatic wait_rx(input int lim, output logic ok);
		ok = 1'b0;
		for (int i = 0; i < lim && !ok; i++) begin
			if (rxf === 1'b1) ok = 1'b1;
			else tick(1);
		end
	endtask
	// mode bits only move under soft reset
	task automatic cfg(input logic m, f, s, ph, pl);
		swrst = 1'b1;
		tick(1);
		master = m;
		fw = f;
		stem = s;
		cpha = ph;
		cpol = pl;
		tick(2);
		`CHK(txf, 1'b1)
		`CHK(busy, 1'b0)
		`CHK(sclk, pl)
		swrst = 1'b0;
		tick(3);
	endtask
	task automatic t_reset;
		`CHK(txf, TX_FLAG_RESET)
		`CHK(rxf, 1'b0)
		`CHK(rbuf, RX_BUF_RESET)
		`CHK({sclk_oen, mosi_oen, miso_oen, sel_oen}, 4'hF)
		pulse_wr(8'h55);
		tick(2);
		`CHK(busy, 1'b0)
		`CHK(txf, 1'b1)
		$display("test reset done");
	endtask
	task automatic t_master(input logic ph, pl, input logic [7:0] tx, rx);
		logic ok;
		cfg(1'b1, 1'b1, STEM_ENABLE, ph, pl);
		remote.arm(rx);
		pulse_wr(tx);
		`CHK(txf, 1'b0)
		`CHK(busy, 1'b1)
		`CHK(creq, busy)
		tick(8);
		`CHK(sel_o, SELECT_ACTIVE)
		`CHK(sel_oen, 1'b0)
		`CHK({sclk_oen, mosi_oen}, 2'b00)
		`CHK(creq, 1'b1)
		wait_rx(100, ok);
		`CHK(ok, 1'b1)
		`CHK(rbuf, rx)
		`CHK(remote.got, tx)
		pulse_rd;
		tick(2);
		`CHK(busy, 1'b0)
		`CHK(creq, 1'b0)
		`CHK(sclk, pl)
		`CHK(sel_o, ~SELECT_ACTIVE)
		$display("test master mode %0d%0d done", pl, ph);
	endtask
	task automatic t_slave(input logic ph, pl, input logic [7:0] tx, rx);
		logic       ok;
		logic [7:0] r;
		cfg(1'b0, ph, STEM_CONFLICT, ph, pl);
		pulse_wr(tx);
		`CHK(busy, 1'b1)
		tick(4);
		remote.send(rx, r);
		tick(1);
		wait_rx(20, ok);
		`CHK(ok, 1'b1)
		`CHK(rbuf, rx)
		`CHK(r, tx)
		`CHK(miso_oen, 1'b0)
		tick(6);
		`CHK(txf, 1'b1)
		`CHK(busy, 1'b0)
		// four-wire slave lets go of its data pin while deselected
		sel_tb = ~SELECT_ACTIVE;
		tick(3);
		`CHK(miso_oen, ph)
		sel_tb = SELECT_ACTIVE;
		pulse_rd;
		$display("test slave mode %0d%0d done", pl, ph);
	endtask
	task automatic t_conflict;
		logic ok;
		sel_tb = ~SELECT_ACTIVE;
		cfg(1'b1, 1'b1, STEM_CONFLICT, 1'b0, 1'b0);
		remote.arm(8'h3C);
		pulse_wr(8'hA5);
		tick(20);
		`CHK(sclk, 1'b0)
		`CHK(busy, 1'b1)
		`CHK(sclk_oen, 1'b1)
		sel_tb = SELECT_ACTIVE;
		tick(20);
		sel_tb = ~SELECT_ACTIVE;
		tick(6);
		`CHK(sclk, 1'b0)
		`CHK(busy, 1'b0)
		wait_rx(80, ok);
		`CHK(ok, 1'b0)
		remote.arm(8'h3C);
		sel_tb = SELECT_ACTIVE;
		tick(4);
		pulse_wr(8'h96);
		wait_rx(100, ok);
		`CHK(ok, 1'b1)
		`CHK(rbuf, 8'h3C)
		`CHK(remote.got, 8'h96)
		pulse_rd;
		$display("test conflict done");
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		rst_i = 1'b1;
		{swrst, master, fw, stem, cpha, cpol, wr, rd} = 8'h80;
		sel_tb = SELECT_ACTIVE;
		tx_data = 8'h00;
		repeat (2) @(posedge clk_i);
		#1 rst_i = 1'b0;
		tick(2);
		t_reset;
		for (int k = 0; k < 4; k++) t_master(k[0], k[1], txt[k], rxt[k]);
		for (int k = 0; k < 4; k++) t_slave(k[0], k[1], rxt[k], txt[k]);
		t_conflict;
		final_report;
	end
	// whole run is near 7 us; allow a wide margin
	initial begin
		#60000;
		error_cnt++;
		final_report;
	end
endmodule
`default_nettype wire
